// ==== pkg/rfc_pkg.sv ====
// constants, field layouts and carriers of the control register bank.
// assumes one 250 MHz core clock; users write rfc_pkg::name.
package rfc_pkg;

	// ************************************************************
	// addressing
	// ************************************************************
	localparam int unsigned ADDR_W    = 6;
	localparam int unsigned DATA_W    = 8;
	localparam int unsigned NUM_REGS  = 6;
	localparam logic [5:0]  ADDR_DSC  = 6'h00;
	localparam logic [5:0]  ADDR_PSEL = 6'h01;
	localparam logic [5:0]  ADDR_TXO  = 6'h02;
	localparam logic [5:0]  ADDR_RXO  = 6'h03;
	localparam logic [5:0]  ADDR_CTH  = 6'h04;
	localparam logic [5:0]  ADDR_CTL  = 6'h05;
	localparam logic [5:0]  ADDR_LAST = ADDR_CTL;

	// ************************************************************
	// serial command byte: bits 7:6 select the access, 5:0 the address
	// ************************************************************
	localparam logic [1:0] CMD_WRITE = 2'h0;
	localparam logic [1:0] CMD_READ  = 2'h1;
	localparam int unsigned CMD_HI   = 7;
	localparam int unsigned CMD_LO   = 6;
	localparam logic [2:0] BIT_LAST  = 3'h7; // bit counter value of the eighth bit

	// ************************************************************
	// reset values and writable masks (reserved bits store nothing)
	// ************************************************************
	localparam logic [7:0] RST_DSC  = 8'h00;
	localparam logic [7:0] RST_PSEL = 8'h00;
	localparam logic [7:0] RST_TXO  = 8'h32;
	localparam logic [7:0] RST_RXO  = 8'hCA;
	localparam logic [7:0] RST_CTH  = 8'h02;
	localparam logic [7:0] RST_CTL  = 8'h9B;
	localparam logic [7:0] MSK_DSC  = 8'h87;
	localparam logic [7:0] MSK_PSEL = 8'hF7;
	localparam logic [7:0] MSK_TXO  = 8'h37;
	localparam logic [7:0] MSK_RXO  = 8'hFF;
	localparam logic [7:0] MSK_CTH  = 8'hEF;
	localparam logic [7:0] MSK_CTL  = 8'hFF;

	// ************************************************************
	// field positions
	// ************************************************************
	localparam int unsigned DSC_STBY = 7, DSC_AGC = 2, DSC_REC = 1, DSC_RF = 0;
	localparam int unsigned PS_CRCN = 7, PS_RAW = 6, PS_AA_HI = 5, PS_AA_LO = 4;
	localparam int unsigned PS_PR_HI = 2, PS_PR_LO = 0;
	localparam int unsigned TX_ONE_HI = 5, TX_ONE_LO = 4, TX_TARI_HI = 2, TX_TARI_LO = 0;
	localparam int unsigned LINK_FREQUENCY_SELECT_HI = 7, LINK_FREQUENCY_SELECT_LO = 4, RX_PRE = 3, RX_COD_HI = 2, RX_COD_LO = 0;
	localparam int unsigned CT_LOWSUP = 7, CT_GAIN2 = 6, CT_GAIN15 = 5, CT_HI_HI = 3, CT_HI_LO = 0;

	// ************************************************************
	// field codes
	// ************************************************************
	localparam logic [1:0] AA_NONE = 2'h0, AA_ACK = 2'h1, AA_ACK_REQRN = 2'h2;
	localparam logic [2:0] PROT_GEN2 = 3'h0, PROT_DIRECT = 3'h1;
	localparam logic [2:0] TARI_6US25 = 3'h0, TARI_12US5 = 3'h1, TARI_25US = 3'h2;
	localparam logic [3:0] LF_40 = 4'h0, LF_160 = 4'h6, LF_250 = 4'h9, LF_320 = 4'hC, LF_640 = 4'hF;
	localparam logic [2:0] COD_FM0 = 3'h0, COD_M2 = 3'h1, COD_M4 = 3'h2, COD_M8 = 3'h3;

	// ************************************************************
	// decoded figures and timing
	// ************************************************************
	localparam int unsigned CLK_PERIOD_PS = 4000;   // 250 MHz
	localparam int unsigned TRCAL_STEP_PS = 100000; // 0.1 us per count
	localparam int unsigned TRCAL_STEP_CYCLES = TRCAL_STEP_PS / CLK_PERIOD_PS;
	localparam logic [15:0] TARI_NS_A = 16'h186A; // 6250 ns
	localparam logic [15:0] TARI_NS_B = 16'h30D4; // 12500 ns
	localparam logic [15:0] TARI_NS_C = 16'h61A8; // 25000 ns
	localparam logic [7:0]  ONE_PCT_0 = 8'h96, ONE_PCT_1 = 8'hA6, ONE_PCT_2 = 8'hB7, ONE_PCT_3 = 8'hC8;
	localparam logic [9:0]  KHZ_40 = 10'h028, KHZ_160 = 10'h0A0, KHZ_250 = 10'h0FA;
	localparam logic [9:0]  KHZ_320 = 10'h140, KHZ_640 = 10'h280;

	// ************************************************************
	// carrier types
	// ************************************************************
	typedef struct packed {
		logic cs_n;
		logic sclk;
		logic mosi;
		logic en;
	} rfc_pins_s;

	typedef struct packed {
		logic        standby;
		logic        agc_enable;
		logic        receiver_enable;
		logic        field_and_receiver_enable;
		logic        crc_bypass;
		logic        raw_decoder_mode;
		logic [1:0]  auto_acknowledge_mode;
		logic [2:0]  protocol;
		logic [1:0]  tx_data_one_length;
		logic [2:0]  tari_code;
		logic [3:0]  link_frequency_select;
		logic        long_preamble;
		logic [2:0]  rx_coding;
		logic [11:0] calibration_time;
		logic        low_supply_phase_adapt;
		logic        indicator_gain_double;
		logic        indicator_gain_one_half_extra;
	} rfc_ctrl_s;

	typedef struct packed {
		logic [15:0] tari_ns;
		logic [7:0]  data_one_pct;
		logic [9:0]  link_freq_khz;
		logic [16:0] calibration_cycles;
	} rfc_decoded_s;

	// reset value of a register by index
	function automatic logic [7:0] rfc_reset_value(input logic [5:0] a);
		unique case (a)
			ADDR_DSC:  return RST_DSC;
			ADDR_PSEL: return RST_PSEL;
			ADDR_TXO:  return RST_TXO;
			ADDR_RXO:  return RST_RXO;
			ADDR_CTH:  return RST_CTH;
			default:   return RST_CTL;
		endcase
	endfunction

	// bits that a write may change, by index
	function automatic logic [7:0] rfc_write_mask(input logic [5:0] a);
		unique case (a)
			ADDR_DSC:  return MSK_DSC;
			ADDR_PSEL: return MSK_PSEL;
			ADDR_TXO:  return MSK_TXO;
			ADDR_RXO:  return MSK_RXO;
			ADDR_CTH:  return MSK_CTH;
			default:   return MSK_CTL;
		endcase
	endfunction

endpackage

// ==== core/rfc_pin_sync.sv ====
// two-flop synchroniser for the pin inputs.
// assumes pins asynchronous to ref_clk_i; the reset value is a constant.
module rfc_pin_sync #(
	parameter int unsigned             W       = 4,
	parameter logic        [W-1:0]     RST_VAL = '0
) (
	input  wire logic         ref_clk_i, // core clock
	input  wire logic         arst_n_i,  // async reset, active low
	input  wire logic [W-1:0] async_i,   // raw pin levels
	output logic      [W-1:0] sync_o     // levels safe to use in the core domain
);

	logic [W-1:0] meta_q;

	// the first stage feeds only the second stage
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			meta_q <= RST_VAL;
			sync_o <= RST_VAL;
		end else begin
			meta_q <= async_i;
			sync_o <= meta_q;
		end
	end

endmodule

// ==== core/rfc_spi_shift.sv ====
// serial byte engine: samples mosi on sclk falling edges, drives miso on
// rising edges, msb first. assumes synchronised inputs, sclk idle low.
module rfc_spi_shift (
	input  wire logic       ref_clk_i,    // core clock
	input  wire logic       arst_n_i,     // async reset, active low
	input  wire logic       active_i,     // chip select asserted and enabled
	input  wire logic       sclk_i,       // synchronised serial clock
	input  wire logic       mosi_i,       // synchronised serial data in
	input  wire logic       load_i,       // pulse: take load_byte_i for output
	input  wire logic [7:0] load_byte_i,  // byte to shift out
	output logic            byte_valid_o, // pulse: rx_byte_o complete
	output logic      [7:0] rx_byte_o,    // last received byte
	output logic            miso_o        // serial data out
);

	logic       sclk_q;
	logic [2:0] cnt_q;
	logic [6:0] rx_sh_q;
	logic [7:0] tx_sh_q;
	logic       rise;
	logic       fall;

	assign rise = sclk_i & ~sclk_q;
	assign fall = ~sclk_i & sclk_q;

	// edge history of the serial clock
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) sclk_q <= 1'b0;
		else           sclk_q <= sclk_i;
	end

	// receive side; the bit count restarts with every frame
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			cnt_q        <= 3'h0;
			rx_sh_q      <= 7'h00;
			rx_byte_o    <= 8'h00;
			byte_valid_o <= 1'b0;
		end else begin
			byte_valid_o <= 1'b0;
			if (!active_i) begin
				cnt_q <= 3'h0;
			end else if (fall) begin
				cnt_q   <= cnt_q + 3'h1;
				rx_sh_q <= {rx_sh_q[5:0], mosi_i};
				if (cnt_q == rfc_pkg::BIT_LAST) begin
					rx_byte_o    <= {rx_sh_q, mosi_i};
					byte_valid_o <= 1'b1;
				end
			end
		end
	end

	// transmit side: a loaded byte appears from the next rising edge
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			tx_sh_q <= 8'h00;
			miso_o  <= 1'b0;
		end else if (load_i) begin
			tx_sh_q <= load_byte_i;
		end else if (active_i && rise) begin
			miso_o  <= tx_sh_q[7];
			tx_sh_q <= {tx_sh_q[6:0], 1'b0};
		end
	end

endmodule

// ==== core/rfc_main_regs.sv ====
// main control and first configuration registers, reached over the serial port.
// assumes pins asynchronous to ref_clk_i and an sclk at most 1/16 of it.
//
// Notes on behaviour
// R1: registers hold defaults while enable pin low
// R2: status bit 7 selects standby mode
// R3: status bit 2 switches gain control on
// R4: status bit 1 enables the receiver
// R5: status bit 0 enables field and receiver
// R6: protocol bit 7 skips receive crc check
// R7: protocol bit 6 disables decoding automatics
// R8: auto acknowledge field bits 5:4, 11 forbidden
// R9: protocol field 000 gen2, 001 direct decoder
// R10: data-one length 1.50 to 2.00 times tari
// R11: tari codes 6.25, 12.5, 25 us
// R12: link frequency codes 40 to 640 kHz
// R13: long preamble bit; short needs miller 4/8
// R14: coding field fm0, miller 2, 4, 8
// R15: twelve-bit calibration time in 0.1 us steps
// R16: high bit 7 adapts phase shifter low supply
// R17: high bits 6,5 give indicator gain 2x/1.5x
// R18: six-bit addresses, read and write serially
// R19: host writes zero to reserved bits
module rfc_main_regs (
	input  wire logic                 ref_clk_i,     // core clock, 250 MHz
	input  wire logic                 arst_n_i,      // async reset, active low
	input  wire logic                 en_i,          // chip enable pin, high = run
	input  wire logic                 spi_cs_n_i,    // serial chip select, active low
	input  wire logic                 spi_sclk_i,    // serial clock, idle low
	input  wire logic                 spi_mosi_i,    // serial data from host
	output logic                      spi_miso_o,    // serial data to host
	output logic                      spi_miso_oe_o, // high while miso is driven
	output rfc_pkg::rfc_ctrl_s        ctrl_o,        // register fields to the core
	output rfc_pkg::rfc_decoded_s     decoded_o,     // fields turned into figures
	output logic                      cfg_error_o    // a forbidden code is stored
);

	// ************************************************************
	// pin synchronisation
	// ************************************************************
	localparam rfc_pkg::rfc_pins_s PINS_IDLE = '{cs_n: 1'b1, sclk: 1'b0, mosi: 1'b0, en: 1'b0};

	rfc_pkg::rfc_pins_s pins_raw;
	rfc_pkg::rfc_pins_s pins_s;

	assign pins_raw = '{cs_n: spi_cs_n_i, sclk: spi_sclk_i, mosi: spi_mosi_i, en: en_i};

	rfc_pin_sync #(
		.W       ($bits(rfc_pkg::rfc_pins_s)),
		.RST_VAL (PINS_IDLE)
	) u_sync (
		.ref_clk_i (ref_clk_i),
		.arst_n_i  (arst_n_i),
		.async_i   (pins_raw),
		.sync_o    (pins_s)
	);

	// ************************************************************
	// serial byte engine
	// ************************************************************
	logic       active;
	logic       byte_valid;
	logic [7:0] rx_byte;
	logic       load;
	logic [7:0] load_byte;

	// a disabled chip ignores the serial port entirely
	assign active = ~pins_s.cs_n & pins_s.en;

	rfc_spi_shift u_shift (
		.ref_clk_i    (ref_clk_i),
		.arst_n_i     (arst_n_i),
		.active_i     (active),
		.sclk_i       (pins_s.sclk),
		.mosi_i       (pins_s.mosi),
		.load_i       (load),
		.load_byte_i  (load_byte),
		.byte_valid_o (byte_valid),
		.rx_byte_o    (rx_byte),
		.miso_o       (spi_miso_o)
	);

	// ************************************************************
	// frame sequencer
	// ************************************************************
	typedef enum logic [1:0] {
		ST_IDLE,
		ST_CMD,
		ST_WRITE,
		ST_READ
	} rfc_state_e;

	rfc_state_e                    state_q;
	logic [rfc_pkg::ADDR_W-1:0]    addr_q;
	logic [rfc_pkg::DATA_W-1:0]    regs_q [rfc_pkg::NUM_REGS];
	logic                          wr_en;
	logic [rfc_pkg::ADDR_W-1:0]    wr_addr;
	logic [rfc_pkg::ADDR_W-1:0]    rd_addr;

	// reads zero outside this bank
	function automatic logic [7:0] read_reg(input logic [5:0] a,
	                                        input logic [7:0] r [rfc_pkg::NUM_REGS]);
		unique case (a)
			rfc_pkg::ADDR_DSC:  return r[0];
			rfc_pkg::ADDR_PSEL: return r[1];
			rfc_pkg::ADDR_TXO:  return r[2];
			rfc_pkg::ADDR_RXO:  return r[3];
			rfc_pkg::ADDR_CTH:  return r[4];
			rfc_pkg::ADDR_CTL:  return r[5];
			default:            return 8'h00;
		endcase
	endfunction

	// command byte carries the address; later bytes go to successive addresses
	assign rd_addr = (state_q == ST_CMD) ? rx_byte[rfc_pkg::ADDR_W-1:0] : addr_q; // R18
	assign load    = byte_valid && (((state_q == ST_CMD) &&
	                 (rx_byte[rfc_pkg::CMD_HI:rfc_pkg::CMD_LO] == rfc_pkg::CMD_READ)) ||
	                 (state_q == ST_READ));
	assign load_byte = read_reg(rd_addr, regs_q); // R18
	assign wr_en   = byte_valid && (state_q == ST_WRITE);
	assign wr_addr = addr_q;

	// state and address pointer; the pointer wraps within six bits
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			state_q <= ST_IDLE;
			addr_q  <= '0;
		end else if (!active) begin
			state_q <= ST_CMD;
		end else begin
			unique case (state_q)
				// held until the frame ends
				ST_IDLE: begin
					state_q <= ST_IDLE;
				end
				ST_CMD: begin
					if (byte_valid) begin
						addr_q <= rx_byte[rfc_pkg::ADDR_W-1:0]; // R18
						if (rx_byte[rfc_pkg::CMD_HI:rfc_pkg::CMD_LO] == rfc_pkg::CMD_WRITE)
							state_q <= ST_WRITE;
						else if (rx_byte[rfc_pkg::CMD_HI:rfc_pkg::CMD_LO] == rfc_pkg::CMD_READ) begin
							state_q <= ST_READ;
							addr_q  <= rx_byte[rfc_pkg::ADDR_W-1:0] + 6'h01;
						end else
							state_q <= ST_IDLE; // unknown access: ignore the rest of the frame
					end
				end
				ST_WRITE: begin
					if (byte_valid) addr_q <= addr_q + 6'h01;
				end
				ST_READ: begin
					if (byte_valid) addr_q <= addr_q + 6'h01;
				end
			endcase
		end
	end

	// miso is only driven during a read frame
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i)                            spi_miso_oe_o <= 1'b0;
		else if (!active)                         spi_miso_oe_o <= 1'b0;
		else if (load && (state_q == ST_CMD))     spi_miso_oe_o <= 1'b1;
	end

	// ************************************************************
	// register storage
	// ************************************************************
	// defaults are forced while the enable pin is low, so a chip wakes with them
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			for (int i = 0; i < rfc_pkg::NUM_REGS; i++)
				regs_q[i] <= rfc_pkg::rfc_reset_value(6'(i)); // R1
		end else if (!pins_s.en) begin
			for (int i = 0; i < rfc_pkg::NUM_REGS; i++)
				regs_q[i] <= rfc_pkg::rfc_reset_value(6'(i)); // R1
		end else if (wr_en && (wr_addr <= rfc_pkg::ADDR_LAST)) begin
			// reserved bits are dropped, so they read zero whatever the host sent
			regs_q[wr_addr[2:0]] <= rx_byte & rfc_pkg::rfc_write_mask(wr_addr); // R19 R18
		end
	end

	// ************************************************************
	// field extraction
	// ************************************************************
	rfc_pkg::rfc_ctrl_s    ctrl_d;
	rfc_pkg::rfc_decoded_s dec_d;
	logic                  err_d;

	always_comb begin
		ctrl_d.standby                   = regs_q[0][rfc_pkg::DSC_STBY]; // R2
		ctrl_d.agc_enable                = regs_q[0][rfc_pkg::DSC_AGC];  // R3
		// receiver runs when asked directly or together with the field
		ctrl_d.receiver_enable           = regs_q[0][rfc_pkg::DSC_REC] |
		                                   regs_q[0][rfc_pkg::DSC_RF];   // R4 R5
		ctrl_d.field_and_receiver_enable = regs_q[0][rfc_pkg::DSC_RF];   // R5
		ctrl_d.crc_bypass                = regs_q[1][rfc_pkg::PS_CRCN];  // R6
		ctrl_d.raw_decoder_mode          = regs_q[1][rfc_pkg::PS_RAW];   // R7
		ctrl_d.auto_acknowledge_mode     = regs_q[1][rfc_pkg::PS_AA_HI:rfc_pkg::PS_AA_LO]; // R8
		ctrl_d.protocol                  = regs_q[1][rfc_pkg::PS_PR_HI:rfc_pkg::PS_PR_LO]; // R9
		ctrl_d.tx_data_one_length        = regs_q[2][rfc_pkg::TX_ONE_HI:rfc_pkg::TX_ONE_LO]; // R10
		ctrl_d.tari_code                 = regs_q[2][rfc_pkg::TX_TARI_HI:rfc_pkg::TX_TARI_LO]; // R11
		ctrl_d.link_frequency_select     = regs_q[3][rfc_pkg::LINK_FREQUENCY_SELECT_HI:rfc_pkg::LINK_FREQUENCY_SELECT_LO]; // R12
		ctrl_d.long_preamble             = regs_q[3][rfc_pkg::RX_PRE];  // R13
		ctrl_d.rx_coding                 = regs_q[3][rfc_pkg::RX_COD_HI:rfc_pkg::RX_COD_LO]; // R14
		ctrl_d.calibration_time          = {regs_q[4][rfc_pkg::CT_HI_HI:rfc_pkg::CT_HI_LO],
		                                    regs_q[5]};                 // R15
		ctrl_d.low_supply_phase_adapt    = regs_q[4][rfc_pkg::CT_LOWSUP]; // R16
		ctrl_d.indicator_gain_double     = regs_q[4][rfc_pkg::CT_GAIN2];  // R17
		ctrl_d.indicator_gain_one_half_extra = regs_q[4][rfc_pkg::CT_GAIN15]; // R17
	end

	// ************************************************************
	// decoding into figures and checking for forbidden codes
	// ************************************************************
	// forbidden codes reach ctrl_o unchanged; cfg_error_o shows them to firmware
	always_comb begin
		err_d = 1'b0;
		unique case (ctrl_d.tx_data_one_length) // R10
			2'h0:    dec_d.data_one_pct = rfc_pkg::ONE_PCT_0;
			2'h1:    dec_d.data_one_pct = rfc_pkg::ONE_PCT_1;
			2'h2:    dec_d.data_one_pct = rfc_pkg::ONE_PCT_2;
			default: dec_d.data_one_pct = rfc_pkg::ONE_PCT_3;
		endcase
		unique case (ctrl_d.tari_code) // R11
			rfc_pkg::TARI_6US25: dec_d.tari_ns = rfc_pkg::TARI_NS_A;
			rfc_pkg::TARI_12US5: dec_d.tari_ns = rfc_pkg::TARI_NS_B;
			rfc_pkg::TARI_25US:  dec_d.tari_ns = rfc_pkg::TARI_NS_C;
			default: begin
				dec_d.tari_ns = 16'h0000;
				err_d         = 1'b1;
			end
		endcase
		unique case (ctrl_d.link_frequency_select) // R12
			rfc_pkg::LF_40:  dec_d.link_freq_khz = rfc_pkg::KHZ_40;
			rfc_pkg::LF_160: dec_d.link_freq_khz = rfc_pkg::KHZ_160;
			rfc_pkg::LF_250: dec_d.link_freq_khz = rfc_pkg::KHZ_250;
			rfc_pkg::LF_320: dec_d.link_freq_khz = rfc_pkg::KHZ_320;
			rfc_pkg::LF_640: dec_d.link_freq_khz = rfc_pkg::KHZ_640;
			default: begin
				dec_d.link_freq_khz = 10'h000;
				err_d               = 1'b1;
			end
		endcase
		// calibration count: 0.1 us steps expressed in core clock cycles
		dec_d.calibration_cycles = 17'(ctrl_d.calibration_time * rfc_pkg::TRCAL_STEP_CYCLES); // R15
		if (ctrl_d.auto_acknowledge_mode > rfc_pkg::AA_ACK_REQRN) err_d = 1'b1; // R8
		if (ctrl_d.protocol > rfc_pkg::PROT_DIRECT)               err_d = 1'b1; // R9
		if (ctrl_d.rx_coding > rfc_pkg::COD_M8)                   err_d = 1'b1; // R14
		// short preamble only with miller 4 or miller 8
		if (!ctrl_d.long_preamble && (ctrl_d.rx_coding != rfc_pkg::COD_M4) &&
		    (ctrl_d.rx_coding != rfc_pkg::COD_M8))                err_d = 1'b1; // R13
	end

	// ************************************************************
	// output registers
	// ************************************************************
	// registered for glitch-free levels, at the price of one cycle of lag
	always_ff @(posedge ref_clk_i or negedge arst_n_i) begin
		if (!arst_n_i) begin
			ctrl_o      <= '0;
			decoded_o   <= '0;
			cfg_error_o <= 1'b0;
		end else begin
			ctrl_o      <= ctrl_d;
			decoded_o   <= dec_d;
			cfg_error_o <= err_d;
		end
	end

endmodule

// ==== testbench/rfc_main_regs_chk.sv ====
// assertions on the ports of the control register bank.
// assumes one clock and all outputs lagging the registers alike.
module rfc_main_regs_chk (
	input wire logic                  ref_clk_i,     // core clock
	input wire logic                  arst_n_i,      // async reset, active low
	input wire logic                  en_i,          // chip enable pin
	input wire logic                  spi_cs_n_i,    // chip select, active low
	input wire logic                  spi_sclk_i,    // serial clock
	input wire logic                  spi_mosi_i,    // host data
	input wire logic                  spi_miso_o,    // device data
	input wire logic                  spi_miso_oe_o, // miso driven
	input wire rfc_pkg::rfc_ctrl_s    ctrl_o,        // register fields
	input wire rfc_pkg::rfc_decoded_s decoded_o,     // decoded figures
	input wire logic                  cfg_error_o    // forbidden code stored
);
	// ************************************************************
	// checks
	// ************************************************************
	logic [1:0] live_q; // outputs keep reset zeros one edge past release
	logic       bad;
	always_ff @(posedge ref_clk_i or negedge arst_n_i)
		if (!arst_n_i) live_q <= 2'h0;
		else           live_q <= {live_q[0], 1'b1};
	default clocking cb @(posedge ref_clk_i); endclocking
	default disable iff (!arst_n_i || !live_q[1]);
	// forbidden codes worked out independently of the design
	assign bad = (ctrl_o.tari_code > 3'h2) || (ctrl_o.auto_acknowledge_mode == 2'h3)
		|| (ctrl_o.protocol > 3'h1) || (ctrl_o.rx_coding > 3'h3)
		|| !(ctrl_o.link_frequency_select inside {4'h0, 4'h6, 4'h9, 4'hC, 4'hF})
		|| (!ctrl_o.long_preamble && (ctrl_o.rx_coding < 3'h2));
	a_tari_decode: assert property (ctrl_o.tari_code <= 3'h2 |-> decoded_o.tari_ns ==
		(ctrl_o.tari_code == 3'h0 ? 16'h186A : ctrl_o.tari_code == 3'h1 ? 16'h30D4 : 16'h61A8))
		else $error("tari decode wrong");
	a_one_decode: assert property (decoded_o.data_one_pct == (ctrl_o.tx_data_one_length[1] ?
		(ctrl_o.tx_data_one_length[0] ? 8'hC8 : 8'hB7) :
		(ctrl_o.tx_data_one_length[0] ? 8'hA6 : 8'h96))) else $error("data one decode wrong");
	a_lf_decode: assert property (ctrl_o.link_frequency_select == 4'hC |->
		decoded_o.link_freq_khz == 10'h140) else $error("link frequency decode wrong");
	a_cal_cycles: assert property (decoded_o.calibration_cycles ==
		17'(ctrl_o.calibration_time) * 17'h19) else $error("calibration cycles wrong");
	a_rf_rx_on: assert property (ctrl_o.field_and_receiver_enable |->
		ctrl_o.receiver_enable) else $error("field enable without receiver");
	a_cfg_error: assert property (cfg_error_o == bad)
		else $error("config error flag wrong");
	a_en_defaults: assert property (!en_i [*6] |-> ctrl_o.calibration_time == 12'h29B
		&& ctrl_o.tari_code == 3'h2 && !ctrl_o.standby) else $error("defaults not held");
	a_oe_idle: assert property (spi_cs_n_i [*5] |-> !spi_miso_oe_o)
		else $error("miso driven outside frame");
endmodule
bind rfc_main_regs rfc_main_regs_chk i_chk (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i),
	.en_i(en_i), .spi_cs_n_i(spi_cs_n_i), .spi_sclk_i(spi_sclk_i), .spi_mosi_i(spi_mosi_i),
	.spi_miso_o(spi_miso_o), .spi_miso_oe_o(spi_miso_oe_o), .ctrl_o(ctrl_o),
	.decoded_o(decoded_o), .cfg_error_o(cfg_error_o));

// ==== testbench/rfc_host_model.sv ====
// host model: one-byte serial write and read frames, msb first.
// assumes it is stepped on core clock falling edges.
module rfc_host_model (
	input  wire logic       ref_clk_i,  // core clock
	input  wire logic       miso_i,     // resolved device data line
	output logic            cs_n_o,     // chip select, active low
	output logic            sclk_o,     // serial clock, idle low
	output logic            mosi_o,     // host data
	output logic            rd_valid_o, // pulse: read byte ready
	output logic      [7:0] rd_data_o   // byte read back
);
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// frames
	// ************************************************************
	initial begin
		{cs_n_o, sclk_o, mosi_o, rd_valid_o, rd_data_o} = {3'h4, 1'h0, 8'h00};
	end
	// phases of ten clocks keep clear of the eight-clock minimum
	task automatic shift(input logic [7:0] tx, output logic [7:0] rx);
		for (int i = 7; i >= 0; i--) begin
			mosi_o = tx[i];
			sclk_o = 1'b1;
			repeat (10) @(negedge ref_clk_i);
			rx[i] = miso_i;
			sclk_o = 1'b0;
			repeat (10) @(negedge ref_clk_i);
		end
	endtask
	task automatic frame(input logic [1:0] cmd, input logic [5:0] a, input logic [7:0] d);
		logic [7:0] rx;
		cs_n_o = 1'b0;
		repeat (4) @(negedge ref_clk_i);
		shift({cmd, a}, rx);
		shift(d, rx);
		repeat (10) @(negedge ref_clk_i);
		cs_n_o = 1'b1;
		rd_data_o = rx;
		@(negedge ref_clk_i);
		rd_valid_o = (cmd == rfc_pkg::CMD_READ);
		repeat (7) @(negedge ref_clk_i);
		rd_valid_o = 1'b0;
	endtask
endmodule

// ==== testbench/rfc_main_regs_tb_top.sv ====
// self-checking bench for the control register bank.
// assumes the host model makes all serial traffic.
module rfc_main_regs_tb_top;
	timeunit 1ns;
	timeprecision 1ps;
	logic                  ref_clk_i, arst_n_i, en_i, tgl = 1'b0, cs_n, sclk, mosi;
	logic                  miso, oe, miso_w, rd_valid, cfg_error;
	logic            [7:0] rd_data, wdat [6];
	logic            [7:0] exp_q [$];
	rfc_pkg::rfc_ctrl_s    ctrl;
	rfc_pkg::rfc_decoded_s dec;
	int                    n_errors = 0, checked = 0, cycles = 0, seed = 42009;
	localparam logic [7:0] RST [6] = '{8'h00, 8'h00, 8'h32, 8'hCA, 8'h02, 8'h9B};
	localparam logic [7:0] MSK [6] = '{8'h87, 8'hF7, 8'h37, 8'hFF, 8'hEF, 8'hFF};
	// ************************************************************
	// harness
	// ************************************************************
	rfc_main_regs i_dut (.ref_clk_i(ref_clk_i), .arst_n_i(arst_n_i), .en_i(en_i),
		.spi_cs_n_i(cs_n), .spi_sclk_i(sclk), .spi_mosi_i(mosi), .spi_miso_o(miso),
		.spi_miso_oe_o(oe), .ctrl_o(ctrl), .decoded_o(dec), .cfg_error_o(cfg_error));
	rfc_host_model i_host (.ref_clk_i(ref_clk_i), .miso_i(miso_w), .cs_n_o(cs_n),
		.sclk_o(sclk), .mosi_o(mosi), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
	// an undriven line toggles so a stale bit cannot pass for data
	assign miso_w = oe ? miso : tgl;
	initial begin
		ref_clk_i = 1'b0;
		forever #2 ref_clk_i = ~ref_clk_i;
	end
	always @(posedge ref_clk_i) begin
		tgl <= ~tgl;
		cycles++;
		if (cycles == 40000) begin
			n_errors++;
			end_of_test();
		end
	end
	task automatic check(input string what, input logic [15:0] seen, input logic [15:0] exp);
		checked++;
		if (seen !== exp) begin
			n_errors++;
			$display("wrong value %s expected %h seen %h", what, exp, seen);
		end
	endtask
	task automatic end_of_test();
		if (n_errors == 0 && checked > 0) $display("ALL TESTS PASSED");
		else $display("TESTS FAILED");
		$finish;
	endtask
	task automatic rd_exp(input logic [5:0] a, input logic [7:0] e);
		exp_q.push_back(e);
		i_host.frame(rfc_pkg::CMD_READ, a, 8'h00);
	endtask
	// read results are compared as they appear, oldest note first
	always @(posedge rd_valid) check("read", rd_data, exp_q.pop_front());
	// ************************************************************
	// scenarios
	// ************************************************************
	initial begin
		arst_n_i = 1'b0;
		en_i = 1'b0;
		repeat (16) @(negedge ref_clk_i);
		arst_n_i = 1'b1;
		en_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		for (int a = 0; a < 6; a++) rd_exp(6'(a), RST[a]);
		check("cal", 16'(ctrl.calibration_time), 16'h029B);
		// random codes may be forbidden, to drive the error flag
		for (int a = 0; a < 6; a++) begin
			wdat[a] = 8'($random(seed)) & MSK[a];
			i_host.frame(rfc_pkg::CMD_WRITE, 6'(a), wdat[a]);
		end
		for (int a = 0; a < 6; a++) rd_exp(6'(a), wdat[a]);
		check("status", 16'({ctrl.standby, ctrl.agc_enable, ctrl.receiver_enable,
			ctrl.field_and_receiver_enable}), 16'({wdat[0][7], wdat[0][2],
			wdat[0][1] | wdat[0][0], wdat[0][0]}));
		check("prot", 16'({ctrl.crc_bypass, ctrl.raw_decoder_mode, ctrl.auto_acknowledge_mode,
			ctrl.protocol}), 16'({wdat[1][7:4], wdat[1][2:0]}));
		check("tx", 16'({ctrl.tx_data_one_length, ctrl.tari_code}),
			16'({wdat[2][5:4], wdat[2][2:0]}));
		check("rx", 16'({ctrl.link_frequency_select, ctrl.long_preamble, ctrl.rx_coding}),
			16'(wdat[3]));
		check("cal", 16'(ctrl.calibration_time), 16'({wdat[4][3:0], wdat[5]}));
		check("gain", 16'({ctrl.low_supply_phase_adapt, ctrl.indicator_gain_double,
			ctrl.indicator_gain_one_half_extra}), 16'(wdat[4][7:5]));
		i_host.frame(rfc_pkg::CMD_WRITE, 6'h06, 8'hFF);
		i_host.frame(rfc_pkg::CMD_WRITE, 6'h3F, 8'hA5);
		rd_exp(6'h06, 8'h00);
		rd_exp(6'h3F, 8'h00);
		i_host.frame(2'h2, 6'h00, 8'hFF);
		rd_exp(6'h00, wdat[0]);
		en_i = 1'b0;
		repeat (12) @(negedge ref_clk_i);
		en_i = 1'b1;
		repeat (8) @(negedge ref_clk_i);
		for (int a = 0; a < 6; a++) rd_exp(6'(a), RST[a]);
		repeat (20) @(negedge ref_clk_i);
		end_of_test();
	end
endmodule
